// >>> src/meter_tamper_pulse_outputs.sv
`timescale 1ns/1ps
module meter_tamper_pulse_outputs
  import meter_pkg::*;
#(
  parameter int          PW               = POWER_W,
  parameter int unsigned WD_PERIOD_CYCLES = WD_PERIOD_CYC,
  parameter int unsigned WD_PULSE_CYCLES  = WD_PULSE_CYC,
  parameter int unsigned MONO_SHORT       = MONO_SHORT_CYC,
  parameter int unsigned MONO_LONG        = MONO_LONG_CYC
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [2:0][PW-1:0]  act_power,
  input  wire logic [2:0][PW-1:0]  fund_act_power,
  input  wire logic [2:0][PW-1:0]  react_power,
  input  wire logic [2:0][PW-1:0]  fund_react_power,
  input  wire logic                current_sum_tamper_flag,
  input  wire logic                phase_sequence_flag,
  input  wire logic [15:0]         hall_dc_level,
  input  wire logic [15:0]         hall_rms_level,
  input  wire logic                zero_cross_signal,
  input  wire logic                supply_ok_pin,
  input  wire logic                latch_sync_pin,
  input  wire logic                spi_sdo,
  input  wire logic                spi_sdo_oe,
  output logic                     serial_data_pin_o,
  output logic                     serial_data_pin_oe,
  output logic                     motor_out_pos,
  output logic                     motor_out_neg,
  output logic                     energy_pulse_pin,
  output logic                     phase_sign_mismatch_flag
);
  logic [CFG_W-1:0]      cfg_ff;
  logic [2:0]            topology;
  logic [1:0]            app_mode;
  logic [1:0]            div_sel;
  logic [1:0]            neg_mode;
  logic                  emi_en;
  logic                  wr_ff;
  logic [7:0]            addr_ff;
  logic [31:0]           hrdata_ff;
  logic                  take;
  logic [1:0]            supply_sync_ff;
  logic                  supply_ok_ff;
  logic [2:0]            latch_sync_ff;
  logic                  latch_req;
  logic [2:0]            sgn;
  logic                  mismatch_ff;
  logic                  tamper_ff;
  logic                  dc_over;
  logic                  rms_over;
  logic                  emi_ff;
  logic [2:0][PW-1:0]    pw_in [4];
  logic signed [PW+1:0]  eng_in [4][4];
  logic [ENERGY_W-1:0]   energy [4][4];
  logic [3:0]            carry [4];
  logic [ENERGY_W-1:0]   snap_ff [4];
  logic [1:0]            sel_type;
  logic [1:0]            sel_ch;
  logic [7:0]            led_cnt_ff;
  logic [31:0]           wd_cnt_ff;
  logic [31:0]           wd_len_ff;
  logic                  wd_hi_ff;
  logic [11:0]           step_cnt_ff;
  logic [11:0]           step_div;
  logic [31:0]           mono_ff;
  coil_e                 coil_ff;
  logic                  next_b_ff;
  logic                  pos_ff;
  logic                  neg_ff;

  assign topology = cfg_ff[CFG_TOPO_LSB +: 3];
  assign app_mode = cfg_ff[CFG_APP_LSB +: 2];
  assign div_sel  = cfg_ff[CFG_DIV_LSB +: 2];
  assign neg_mode = cfg_ff[CFG_NEG_LSB +: 2];
  assign emi_en   = cfg_ff[CFG_EMI_BIT] & app_mode[1];

  // Bus slave: zero wait states, always OKAY
  assign take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff   <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_ff   <= take & hwrite;
      addr_ff <= take ? haddr[7:0] : addr_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= CFG_RESET;
    end else if (wr_ff && addr_ff == CFG_OFS) begin
      cfg_ff <= hwdata[CFG_W-1:0];
    end
  end

  // Read data is captured in the address phase, so a read right after a write
  // to the same register returns the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr[7:0])
        CFG_OFS:         hrdata_ff <= {20'h0_0000, cfg_ff};
        STATUS_OFS:      hrdata_ff <= {24'h00_0000, supply_ok_ff, coil_ff == COIL_B,
                                       coil_ff == COIL_A, energy_pulse_pin, wd_hi_ff,
                                       phase_sequence_flag, current_sum_tamper_flag,
                                       mismatch_ff};
        SNAP_OFS:        hrdata_ff <= {12'h000, snap_ff[0]};
        SNAP_OFS + 8'h4: hrdata_ff <= {12'h000, snap_ff[1]};
        SNAP_OFS + 8'h8: hrdata_ff <= {12'h000, snap_ff[2]};
        SNAP_OFS + 8'hC: hrdata_ff <= {12'h000, snap_ff[3]};
        default:         hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Pins from outside the clock domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_sync_ff <= 2'b00;
      latch_sync_ff  <= 3'b000;
    end else begin
      supply_sync_ff <= {supply_sync_ff[0], supply_ok_pin};
      latch_sync_ff  <= {latch_sync_ff[1:0], latch_sync_pin};
    end
  end

  assign supply_ok_ff = supply_sync_ff[1];
  assign latch_req    = (latch_sync_ff[1] & ~latch_sync_ff[2])
                      | (wr_ff && addr_ff == LATCH_OFS && hwdata[0]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int t = 0; t < 4; t++) snap_ff[t] <= '0;
    end else if (latch_req) begin
      for (int t = 0; t < 4; t++) snap_ff[t] <= energy[t][0];
    end
  end

  // Tamper flags
  always_comb begin
    for (int p = 0; p < 3; p++) sgn[p] = ~act_power[p][PW-1];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mismatch_ff <= 1'b0;
      emi_ff      <= 1'b0;
      tamper_ff   <= 1'b0;
    end else begin
      mismatch_ff <= (sgn != 3'b000) && (sgn != 3'b111);
      emi_ff      <= emi_en & (dc_over | rms_over);
      if (topology <= TOPO_3PH_MAX) begin
        tamper_ff <= current_sum_tamper_flag | phase_sequence_flag
                   | mismatch_ff | emi_ff;
      end else begin
        tamper_ff <= current_sum_tamper_flag | emi_ff;
      end
    end
  end

  hysteresis_detect #(.THRESH(EMI_THRESH), .HYST(EMI_HYST)) u_dc_det (
    .hclk   (hclk),
    .hresetn(hresetn),
    .level  (hall_dc_level),
    .over   (dc_over)
  );

  hysteresis_detect #(.THRESH(EMI_THRESH), .HYST(EMI_HYST)) u_rms_det (
    .hclk   (hclk),
    .hresetn(hresetn),
    .level  (hall_rms_level),
    .over   (rms_over)
  );

  assign phase_sign_mismatch_flag = mismatch_ff;
  // Standalone: pin carries tamper; peripheral: left to the serial register port
  assign serial_data_pin_o  = app_mode[1] ? tamper_ff : spi_sdo;
  assign serial_data_pin_oe = app_mode[1] | spi_sdo_oe;

  // Energy integration: types P, F, Q, R; channel 0 three-phase, 1..3 R, S, T
  assign pw_in[0] = act_power;
  assign pw_in[1] = fund_act_power;
  assign pw_in[2] = react_power;
  assign pw_in[3] = fund_react_power;

  function automatic logic signed [PW+1:0] cond_ph(input logic [PW-1:0] raw,
                                                    input logic [1:0]    mode,
                                                    input logic          act);
    logic signed [PW+1:0] v;
    v = (PW+2)'($signed(raw));
    if (act && v < 0 && mode == NEG_ABS) v = -v;
    if (act && v < 0 && mode == NEG_CLAMP_PH) v = '0;
    return v;
  endfunction : cond_ph

  always_comb begin
    for (int t = 0; t < 4; t++) begin
      eng_in[t][0] = '0;
      for (int c = 1; c < 4; c++) begin
        eng_in[t][c] = cond_ph(pw_in[t][c-1], neg_mode, t < 2);
        eng_in[t][0] = eng_in[t][0] + eng_in[t][c];
      end
      if (t < 2 && neg_mode == NEG_FERRARIS && eng_in[t][0] < 0) eng_in[t][0] = '0;
      // Halved input doubles the weight of one energy count
      if (t > 0 && topology == TOPO_SPLIT) begin
        for (int c = 0; c < 4; c++) eng_in[t][c] = eng_in[t][c] >>> 1;
      end
    end
  end

  for (genvar t = 0; t < 4; t++) begin : g_type
    for (genvar c = 0; c < 4; c++) begin : g_ch
      energy_integrator #(.EW(ENERGY_W), .IW(PW + 2)) u_int (
        .hclk   (hclk),
        .hresetn(hresetn),
        .power  (eng_in[t][c]),
        .energy (energy[t][c]),
        .carry  (carry[t][c])
      );
    end
  end

  // Pulse pin selection and stretch
  assign sel_type = app_mode[1] ? 2'b00
                  : {cfg_ff[CFG_TYPE_BIT], cfg_ff[CFG_FUND_BIT]};
  assign sel_ch   = (app_mode == APP_PERIPH_ZC) ? div_sel : 2'b00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_cnt_ff <= 8'h00;
    end else if (carry[sel_type][sel_ch]) begin
      led_cnt_ff <= 8'(LED_PULSE_CYC);
    end else if (led_cnt_ff != 8'h00) begin
      led_cnt_ff <= led_cnt_ff - 8'h01;
    end
  end

  assign energy_pulse_pin = led_cnt_ff != 8'h00;

  // Watchdog: a latch request restarts the interval
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_ff <= 32'h0000_0000;
      wd_len_ff <= 32'h0000_0000;
      wd_hi_ff  <= 1'b0;
    end else if (!supply_ok_ff) begin
      wd_cnt_ff <= 32'h0000_0000;
      wd_len_ff <= 32'h0000_0000;
      wd_hi_ff  <= 1'b1;
    end else begin
      if (latch_req || wd_cnt_ff == 32'(WD_PERIOD_CYCLES - 1)) begin
        wd_cnt_ff <= 32'h0000_0000;
      end else begin
        wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
      end
      if (!latch_req && wd_cnt_ff == 32'(WD_PERIOD_CYCLES - 1)) begin
        wd_hi_ff  <= 1'b1;
        wd_len_ff <= 32'(WD_PULSE_CYCLES - 1);
      end else if (wd_len_ff != 32'h0000_0000) begin
        wd_len_ff <= wd_len_ff - 32'h0000_0001;
      end else begin
        wd_hi_ff <= 1'b0;
      end
    end
  end

  // Stepper: divide three-phase active pulses, then a mono-flop per step
  always_comb begin
    case (div_sel)
      2'd0:    step_div = STEP_BASE_DIV0;
      2'd1:    step_div = STEP_BASE_DIV1;
      2'd2:    step_div = STEP_BASE_DIV2;
      default: step_div = STEP_BASE_DIV3;
    endcase
    if (cfg_ff[CFG_TYPE_BIT]) step_div = 12'(step_div * STEP_LONG_MUL);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_cnt_ff <= 12'h000;
      mono_ff     <= 32'h0000_0000;
      coil_ff     <= COIL_IDLE;
      next_b_ff   <= 1'b0;
    end else if (app_mode == APP_PERIPH_ZC) begin
      step_cnt_ff <= 12'h000;
      mono_ff     <= 32'h0000_0000;
      coil_ff     <= COIL_IDLE;
    end else begin
      if (carry[0][0]) begin
        step_cnt_ff <= (step_cnt_ff >= step_div - 12'h001) ? 12'h000 : step_cnt_ff + 12'h001;
      end
      case (coil_ff)
        COIL_IDLE: begin
          if (carry[0][0] && step_cnt_ff >= step_div - 12'h001) begin
            coil_ff   <= next_b_ff ? COIL_B : COIL_A;
            next_b_ff <= ~next_b_ff;
            mono_ff   <= cfg_ff[CFG_TYPE_BIT] ? 32'(MONO_LONG - 1) : 32'(MONO_SHORT - 1);
          end
        end
        COIL_A, COIL_B: begin
          if (mono_ff == 32'h0000_0000) begin
            coil_ff <= COIL_IDLE;
          end else begin
            mono_ff <= mono_ff - 32'h0000_0001;
          end
        end
        default: coil_ff <= COIL_IDLE;
      endcase
    end
  end

  // Motor pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_ff <= 1'b0;
      neg_ff <= 1'b0;
    end else if (app_mode == APP_PERIPH_ZC) begin
      pos_ff <= zero_cross_signal;
      neg_ff <= wd_hi_ff;
    end else begin
      pos_ff <= coil_ff == COIL_A;
      neg_ff <= coil_ff == COIL_B;
    end
  end

  assign motor_out_pos = pos_ff;
  assign motor_out_neg = neg_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_mismatch;
    1'b1 |=> mismatch_ff == ($past(sgn) != 3'b000 && $past(sgn) != 3'b111);
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch flag wrong");

  property p_sd_tamper;
    (mismatch_ff && app_mode[1] && topology <= TOPO_3PH_MAX) ##1 app_mode[1]
      |-> serial_data_pin_o && serial_data_pin_oe;
  endproperty
  a_sd_tamper: assert property (p_sd_tamper) else $error("tamper not on pin");

  property p_emi_gate;
    !emi_en |=> !emi_ff;
  endproperty
  a_emi_gate: assert property (p_emi_gate) else $error("emi without enable");

  property p_emi_set;
    (emi_en && hall_dc_level > EMI_THRESH) ##1 emi_en |=> emi_ff;
  endproperty
  a_emi_set: assert property (p_emi_set) else $error("emi missed");

  property p_zc;
    app_mode == APP_PERIPH_ZC |=> motor_out_pos == $past(zero_cross_signal);
  endproperty
  a_zc: assert property (p_zc) else $error("zero cross not on pin");

  property p_wd_neg;
    app_mode == APP_PERIPH_ZC |=> motor_out_neg == $past(wd_hi_ff);
  endproperty
  a_wd_neg: assert property (p_wd_neg) else $error("watchdog not on pin");

  property p_wd_width;
    $rose(wd_hi_ff) && supply_ok_ff |-> wd_hi_ff [*8];
  endproperty
  a_wd_width: assert property (p_wd_width) else $error("watchdog pulse short");

  property p_wd_restart;
    latch_req && supply_ok_ff |=> wd_cnt_ff == 32'h0000_0000;
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("latch no restart");

  property p_wd_supply;
    !supply_ok_ff |=> wd_hi_ff;
  endproperty
  a_wd_supply: assert property (p_wd_supply) else $error("watchdog low at low supply");

  property p_led_app1;
    app_mode == APP_PERIPH_STEP && carry[sel_type][0] |=> energy_pulse_pin;
  endproperty
  a_led_app1: assert property (p_led_app1) else $error("pulse pin missed");
endmodule : meter_tamper_pulse_outputs

// >>> common/meter_pkg.sv
package meter_pkg;
  localparam int          ENERGY_W        = 20;
  localparam int          POWER_W         = 16;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int unsigned WD_PERIOD_NS    = 1_600_000_000;
  localparam int unsigned WD_PULSE_NS     = 16_000_000;
  localparam int unsigned MONO_SHORT_NS   = 31_250_000;
  localparam int unsigned MONO_LONG_NS    = 156_250_000;
  localparam int unsigned LED_PULSE_NS    = 1_000;
  localparam int unsigned WD_PERIOD_CYC   = WD_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned WD_PULSE_CYC    = (WD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MONO_SHORT_CYC  = (MONO_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MONO_LONG_CYC   = (MONO_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LED_PULSE_CYC   = (LED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  CFG_OFS         = 8'h00;
  localparam logic [7:0]  STATUS_OFS      = 8'h04;
  localparam logic [7:0]  LATCH_OFS       = 8'h08;
  localparam logic [7:0]  SNAP_OFS        = 8'h10;
  localparam int          CFG_W           = 12;
  localparam int          CFG_TOPO_LSB    = 0;
  localparam int          CFG_APP_LSB     = 3;
  localparam int          CFG_EMI_BIT     = 5;
  localparam int          CFG_TYPE_BIT    = 6;
  localparam int          CFG_FUND_BIT    = 7;
  localparam int          CFG_DIV_LSB     = 8;
  localparam int          CFG_NEG_LSB     = 10;
  localparam logic [CFG_W-1:0] CFG_RESET  = 12'h000;
  localparam logic [2:0]  TOPO_3PH_MAX    = 3'h2;
  localparam logic [2:0]  TOPO_SPLIT      = 3'h3;
  localparam logic [1:0]  APP_PERIPH_ZC   = 2'h0;
  localparam logic [1:0]  APP_PERIPH_STEP = 2'h1;
  localparam logic [1:0]  NEG_FERRARIS    = 2'h0;
  localparam logic [1:0]  NEG_ABS         = 2'h1;
  localparam logic [1:0]  NEG_CLAMP_PH    = 2'h2;
  localparam logic [15:0] EMI_THRESH      = 16'h1000;
  localparam logic [15:0] EMI_HYST        = 16'h0100;
  localparam logic [11:0] STEP_BASE_DIV0  = 12'h040;
  localparam logic [11:0] STEP_BASE_DIV1  = 12'h080;
  localparam logic [11:0] STEP_BASE_DIV2  = 12'h020;
  localparam logic [11:0] STEP_BASE_DIV3  = 12'h100;
  localparam logic [11:0] STEP_LONG_MUL   = 12'h00A;
  typedef enum logic [1:0] {COIL_IDLE, COIL_A, COIL_B} coil_e;
endpackage : meter_pkg

// >>> src/energy_integrator.sv
`timescale 1ns/1ps
module energy_integrator #(
  parameter int EW = 20,
  parameter int IW = 18
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic signed [IW-1:0] power,
  output logic             [EW-1:0] energy,
  output logic                      carry
);
  logic        [EW-1:0] energy_ff;
  logic                 carry_ff;
  logic signed [EW+1:0] nxt_sum;

  // Wraps in either direction; a wrap is one energy quantum on the pulse train
  assign nxt_sum = $signed({2'b00, energy_ff}) + (EW+2)'(power);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      energy_ff <= '0;
      carry_ff  <= 1'b0;
    end else begin
      energy_ff <= nxt_sum[EW-1:0];
      carry_ff  <= nxt_sum[EW+1] | nxt_sum[EW];
    end
  end

  assign energy = energy_ff;
  assign carry  = carry_ff;
endmodule : energy_integrator

// >>> src/hysteresis_detect.sv
`timescale 1ns/1ps
module hysteresis_detect #(
  parameter logic [15:0] THRESH = 16'h1000,
  parameter logic [15:0] HYST   = 16'h0100
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] level,
  output logic             over
);
  logic over_ff;

  // Clears only well below the threshold so a level near it does not chatter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      over_ff <= 1'b0;
    end else if (level > THRESH) begin
      over_ff <= 1'b1;
    end else if (level < THRESH - HYST) begin
      over_ff <= 1'b0;
    end
  end

  assign over = over_ff;
endmodule : hysteresis_detect

// >>> verification/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic        hclk,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             latch_sync_pin
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    latch_sync_pin = 1'b0;
  end
  // Single word transfer; waits on hready even though this slave never stalls
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  // In peripheral mode the controller spots field tampering from the hall levels itself
  function automatic logic emi_seen(input logic [15:0] dc, input logic [15:0] rms);
    return (dc > meter_pkg::EMI_THRESH) || (rms > meter_pkg::EMI_THRESH);
  endfunction : emi_seen
  // A healthy controller latches results regularly, which services the watchdog
  task automatic latch();
    @(posedge hclk);
    latch_sync_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    latch_sync_pin <= 1'b0;
  endtask : latch
endmodule : host_model

// >>> verification/meter_tamper_pulse_outputs_tb.sv
`timescale 1ns/1ps
module meter_tamper_pulse_outputs_tb;
  import meter_pkg::*;
  logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [2:0][15:0] act_power;
  logic [2:0][15:0] fund_act, react, fund_react;
  logic [15:0]      hall_dc_level, hall_rms_level;
  logic             cur_sum, phase_seq, zero_cross, supply_ok, latch_pin, sdo, sdo_oe;
  logic             ser_o, ser_oe, mpos, mneg, led_pin, mismatch;
  int               n_errors = 0;
  int               total_checks = 0;
  int               hi;
  // Negative R, S, T then expected mismatch flag
  logic [3:0]       rows [6] = '{4'b0000, 4'b1110, 4'b1001, 4'b0101, 4'b0011, 4'b1101};

  host_model host_u (.hclk(hclk), .hrdata(hrdata), .hreadyout(hreadyout), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .latch_sync_pin(latch_pin));

  // Short watchdog counts keep the run brief
  meter_tamper_pulse_outputs #(.WD_PERIOD_CYCLES(200), .WD_PULSE_CYCLES(10),
    .MONO_SHORT(20), .MONO_LONG(40)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .act_power(act_power),
    .fund_act_power(fund_act), .react_power(react), .fund_react_power(fund_react),
    .current_sum_tamper_flag(cur_sum), .phase_sequence_flag(phase_seq),
    .hall_dc_level(hall_dc_level), .hall_rms_level(hall_rms_level),
    .zero_cross_signal(zero_cross), .supply_ok_pin(supply_ok), .latch_sync_pin(latch_pin),
    .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .serial_data_pin_o(ser_o),
    .serial_data_pin_oe(ser_oe), .motor_out_pos(mpos), .motor_out_neg(mneg),
    .energy_pulse_pin(led_pin), .phase_sign_mismatch_flag(mismatch));

  always #4 hclk = ~hclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rd);
    cyc(4);
  endtask : wr
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0000_0000, rd);
    check(rd, exp);
  endtask : rd_chk
  task automatic sig(input logic [2:0] neg);
    for (int i = 0; i < 3; i++) act_power[i] <= {neg[2-i], 15'h0100};
  endtask : sig
  // Counts high cycles of the negative motor pin (sel 0), pulse pin (1) or positive pin (2)
  task automatic count_high(input int n, input int sel);
    hi = 0;
    repeat (n) begin
      @(posedge hclk);
      if (((sel == 1) ? led_pin : (sel == 2) ? mpos : mneg) === 1'b1) hi++;
    end
  endtask : count_high
  // Snapshot difference across exactly 10 cycles of a known power on every input
  task automatic energy_gain(input logic [31:0] a, input logic [19:0] exp);
    logic [19:0] e0;
    {act_power, fund_act, react, fund_react} <= {12{16'h0000}};
    host_u.xfer(1'b1, LATCH_OFS, 32'h0000_0001, rd);
    host_u.xfer(1'b0, a, 32'h0000_0000, rd);
    e0 = rd[19:0];
    {act_power, fund_act, react, fund_react} <= {12{16'h0100}};
    cyc(10);
    {act_power, fund_act, react, fund_react} <= {12{16'h0000}};
    host_u.xfer(1'b1, LATCH_OFS, 32'h0000_0001, rd);
    host_u.xfer(1'b0, a, 32'h0000_0000, rd);
    check(20'(rd[19:0] - e0), exp);
  endtask : energy_gain

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {act_power, fund_act, react, fund_react} = {12{16'h0000}};
    {hall_dc_level, hall_rms_level} = 32'h0000_0000;
    {cur_sum, phase_seq, zero_cross, supply_ok, sdo, sdo_oe} = 6'h00;
    cyc(10);
    check({mpos, mneg, led_pin, mismatch, hreadyout}, 5'h01);
    hresetn <= 1'b1;
    cyc(4);
    check(mneg, 1'b1);
    rd_chk(CFG_OFS, 32'h0000_0000);
    rd_chk(32'h0000_0040, 32'h0000_0000);
    wr(CFG_OFS, 32'h0000_0C80);
    rd_chk(CFG_OFS, 32'h0000_0C80);
    wr(CFG_OFS, 32'h0000_0000);
    foreach (rows[i]) begin
      sig(rows[i][3:1]);
      cyc(4);
      check(mismatch, rows[i][0]);
    end
    {sdo, sdo_oe, zero_cross} <= 3'h7;
    cyc(4);
    check({ser_o, ser_oe, mpos}, 3'h7);
    {sdo, sdo_oe} <= 2'h0;
    cyc(4);
    check({ser_o, ser_oe}, 2'h0);
    wr(CFG_OFS, 32'h0000_0010);
    check({ser_o, ser_oe}, 2'h3);
    wr(CFG_OFS, 32'h0000_0014);
    check(ser_o, 1'b0);
    cur_sum <= 1'b1;
    cyc(4);
    check(ser_o, 1'b1);
    cur_sum <= 1'b0;
    phase_seq <= 1'b1;
    sig(3'h0);
    wr(CFG_OFS, 32'h0000_0012);
    check(ser_o, 1'b1);
    phase_seq <= 1'b0;
    hall_dc_level <= 16'h1100;
    cyc(4);
    check(ser_o, 1'b0);
    wr(CFG_OFS, 32'h0000_0032);
    check(ser_o, 1'b1);
    hall_dc_level <= 16'h0F80;
    cyc(4);
    check(ser_o, 1'b1);
    hall_dc_level <= 16'h0E00;
    cyc(4);
    check(ser_o, 1'b0);
    hall_rms_level <= 16'h1100;
    cyc(4);
    check(ser_o, 1'b1);
    wr(CFG_OFS, 32'h0000_0022);
    check({ser_o, ser_oe, host_u.emi_seen(hall_dc_level, hall_rms_level)}, 3'h1);
    hall_rms_level <= 16'h0000;
    wr(CFG_OFS, 32'h0000_0000);
    supply_ok <= 1'b1;
    host_u.latch();
    cyc(20);
    count_high(220, 0);
    check(hi, 10);
    fork
      count_high(560, 0);
      repeat (4) begin
        host_u.latch();
        cyc(140);
      end
    join
    check(hi, 0);
    supply_ok <= 1'b0;
    cyc(5);
    check(mneg, 1'b1);
    energy_gain(SNAP_OFS, 20'h0_1E00);
    wr(CFG_OFS, 32'h0000_0003);
    energy_gain(SNAP_OFS, 20'h0_1E00);
    energy_gain(SNAP_OFS + 8'h4, 20'h0_0F00);
    energy_gain(SNAP_OFS + 8'h8, 20'h0_0F00);
    wr(CFG_OFS, 32'h0000_0000);
    for (int i = 0; i < 3; i++) act_power[i] <= 16'h7FFF;
    count_high(300, 1);
    check(hi != 0, 1'b1);
    wr(CFG_OFS, 32'h0000_0040);
    cyc(200);
    count_high(300, 1);
    check(hi, 0);
    // Power on R only, so the T channel stays silent while the three-phase sum does not
    act_power <= {16'h0000, 16'h0000, 16'h7FFF};
    wr(CFG_OFS, 32'h0000_0100);
    count_high(300, 1);
    check(hi != 0, 1'b1);
    wr(CFG_OFS, 32'h0000_0300);
    cyc(200);
    count_high(300, 1);
    check(hi, 0);
    wr(CFG_OFS, 32'h0000_0308);
    count_high(300, 1);
    check(hi != 0, 1'b1);
    wr(CFG_OFS, 32'h0000_03C8);
    cyc(200);
    count_high(300, 1);
    check(hi, 0);
    fund_react <= {16'h0000, 16'h0000, 16'h7FFF};
    count_high(300, 1);
    check(hi != 0, 1'b1);
    for (int i = 0; i < 3; i++) act_power[i] <= 16'h7FFF;
    wr(CFG_OFS, 32'h0000_0208);
    // The wait already saw the first of the coil's high cycles
    while (mpos !== 1'b1) @(posedge hclk);
    count_high(40, 2);
    check(hi + 1, 20);
    while (mneg !== 1'b1) @(posedge hclk);
    count_high(40, 0);
    check(hi + 1, 20);
    hresetn <= 1'b0;
    cyc(2);
    check({mpos, mneg, led_pin, mismatch}, 4'h0);
    close_out();
  end

  // Whole run is a few thousand cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    close_out();
  end
endmodule : meter_tamper_pulse_outputs_tb
